/* File: mpf_pkg.sv */
// Function
// - Five selectable port configurations set active ports.
// - Unselected ports are disabled, issue nothing.
// - Unidirectional ports carry only their direction.
// - Optional AXI4 bridge per port, else native.
// - User address split order selectable.
// - Row-bank-column bursts roll into next bank.
// - Narrow burst logic optional; off forbids narrow.
// - Write response early or after all ports.
// - Auto-precharge closes page per port transaction.
// - Round robin default, custom slot table optional.
// - First slot entry has highest priority.
// - User request retriggers DQ/DQS calibration.
// - Training pattern written to reserved address first.
// - Simulation bypass skips initial calibration.
package mpf_pkg;
  // ==========================================
  // Geometry
  localparam int NP = 4;
  localparam int AW = 28;
  localparam int COLW = 10;
  localparam int BANKW = 3;
  localparam int ROWW = 15;
  localparam int PW = 2;
  localparam logic [NP-1:0] UNI_MASK = 4'hc;
  // Active port mask per configuration 0..4
  localparam logic [4:0][NP-1:0] CFG_MASK = {4'h1, 4'h5, 4'h3, 4'h7, 4'hf};
  localparam logic [2:0] CFG_LAST = 3'h4;
  // ==========================================
  // Register map
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_PORT = 8'h04;
  localparam logic [7:0] A_ARB0 = 8'h08;
  localparam logic [7:0] A_ARB1 = 8'h0c;
  localparam logic [7:0] A_CAL = 8'h10;
  localparam logic [7:0] A_STAT = 8'h14;
  localparam logic [31:0] CTRL_WMASK = 32'h0000001f;
  localparam logic [31:0] PORT_WMASK = 32'h001fffff;
  localparam logic [31:0] CTRL_RST = 32'h00000000;
  localparam logic [31:0] PORT_RST = 32'h0010000f;
  localparam logic [31:0] ARB_RST = 32'he4e4e4e4;
  localparam logic [31:0] CAL_RST = 32'h00000000;
  // Field positions
  localparam int C_CFG = 0;
  localparam int C_MAP = 3;
  localparam int C_CUST = 4;
  localparam int P_EN = 0;
  localparam int P_DIR = 4;
  localparam int P_AXI = 8;
  localparam int P_STR = 12;
  localparam int P_AP = 16;
  localparam int P_NAR = 20;
  localparam int S_DONE = 0;
  localparam int S_BUSY = 1;
  localparam int S_SLOT = 2;
  localparam int S_ERR = 8;
  // ==========================================
  // Timing and states
  localparam logic [7:0] CAL_CYC = 8'h40;
  typedef enum logic [1:0] {
    ST_INIT = 2'b00,
    ST_CALWR = 2'b01,
    ST_CALRUN = 2'b10,
    ST_RUN = 2'b11
  } mpf_cal_t;
endpackage

/* File: mpf_front_end.sv */
`timescale 1ns/1ns
module mpf_front_end import mpf_pkg::*; #(
  parameter bit SIM_BYPASS_CAL = 1'b0
) (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [31:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic [NP-1:0] CMD_VALID_I,
  input wire logic [NP-1:0] CMD_WRITE_I,
  input wire logic [NP-1:0] CMD_NARROW_I,
  input wire logic [NP*AW-1:0] CMD_ADDR_I,
  output logic [NP-1:0] CMD_READY_O,
  output logic [NP-1:0] WRESP_O,
  output logic MEM_CMD_VALID_O,
  output logic MEM_WRITE_O,
  output logic MEM_AP_O,
  output logic MEM_CAL_O,
  output logic [ROWW-1:0] MEM_ROW_O,
  output logic [BANKW-1:0] MEM_BANK_O,
  output logic [COLW-1:0] MEM_COL_O,
  output logic [PW-1:0] MEM_PORT_O,
  input wire logic MEM_CMD_READY_I,
  input wire logic MEM_WDONE_I,
  input wire logic [PW-1:0] MEM_WDONE_PORT_I,
  input wire logic RECAL_REQ_I,
  output logic CAL_DONE_O
);
  typedef struct packed {
    mpf_cal_t cal;
    logic [7:0] calcnt;
    logic recal_prev;
    logic caldone;
    logic [31:0] ctrl;
    logic [31:0] port;
    logic [31:0] arb0;
    logic [31:0] arb1;
    logic [31:0] caladdr;
    logic err;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic mvalid;
    logic mwrite;
    logic ap;
    logic mcal;
    logic [ROWW-1:0] row;
    logic [BANKW-1:0] bank;
    logic [COLW-1:0] col;
    logic [PW-1:0] mport;
    logic [2:0] slot;
    logic [PW-1:0] rr;
    logic [NP-1:0] cready;
    logic [NP-1:0] wresp;
    logic [NP-1:0] wpend;
    logic [7:0] outst;
  } mpf_st_t;

  mpf_st_t q;
  mpf_st_t d;
  logic [NP-1:0] act;
  logic [NP-1:0] elig;
  logic [NP-1:0][PW-1:0] ent;
  logic [63:0] tbl;
  logic [AW-1:0] addr_sel;
  logic [PW-1:0] pick;
  logic found;
  logic issue;
  logic mem_free;
  logic recal_edge;

  // ==========================================
  // Port qualification and ranking
  assign act = ((q.ctrl[C_CFG +: 3] > CFG_LAST) ? '0 : CFG_MASK[q.ctrl[C_CFG +: 3]])
               & q.port[P_EN +: NP];
  // A port granted last cycle sits out one cycle, so a held valid is not taken twice
  assign elig = CMD_VALID_I & act & ~q.cready;
  assign tbl = {q.arb1, q.arb0};
  assign mem_free = !q.mvalid || MEM_CMD_READY_I;
  assign recal_edge = RECAL_REQ_I && !q.recal_prev;

  for (genvar k = 0; k < NP; k++) begin : g_rank
    // Slot entry k outranks entry k+1
    assign ent[k] = q.ctrl[C_CUST] ? tbl[{q.slot, 3'h0} + 6'(k * PW) +: PW]
                                   : q.rr + PW'(k);
  end

  always_comb begin
    pick = '0;
    found = 1'b0;
    for (int k = NP - 1; k >= 0; k--) begin
      if (elig[ent[k]]) begin
        pick = ent[k];
        found = 1'b1;
      end
    end
  end

  assign addr_sel = CMD_ADDR_I[pick * AW +: AW];

  // ==========================================
  // Next state
  always_comb begin
    logic bad;
    bad = 1'b0;
    d = q;
    issue = 1'b0;
    d.cready = '0;
    d.wresp = '0;
    d.pready = 1'b0;
    d.pslverr = 1'b0;
    d.recal_prev = RECAL_REQ_I;
    if (q.mvalid && MEM_CMD_READY_I) begin
      d.mvalid = 1'b0;
    end
    // APB: one wait state, data registered before the completing edge
    if (PSEL_I && PENABLE_I && !q.pready) begin
      d.pready = 1'b1;
      d.prdata = '0;
      case (PADDR_I[7:0])
        A_CTRL: d.prdata = q.ctrl;
        A_PORT: d.prdata = q.port;
        A_ARB0: d.prdata = q.arb0;
        A_ARB1: d.prdata = q.arb1;
        A_CAL: d.prdata = q.caladdr;
        A_STAT: begin
          d.prdata[S_DONE] = q.caldone;
          d.prdata[S_BUSY] = q.mvalid;
          d.prdata[S_SLOT +: 3] = q.slot;
          d.prdata[S_ERR] = q.err;
        end
        default: d.pslverr = 1'b1;
      endcase
    end
    if (PSEL_I && PENABLE_I && q.pready && PWRITE_I) begin
      case (PADDR_I[7:0])
        A_CTRL: d.ctrl = PWDATA_I & CTRL_WMASK;
        A_PORT: d.port = PWDATA_I & PORT_WMASK;
        A_ARB0: d.arb0 = PWDATA_I;
        A_ARB1: d.arb1 = PWDATA_I;
        A_CAL: d.caladdr = PWDATA_I;
        A_STAT: begin
          if (PWDATA_I[S_ERR]) begin
            d.err = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // Write responses; strict ones wait for an empty write pipe
    for (int p = 0; p < NP; p++) begin
      if (q.wpend[p] && q.outst == 8'h00) begin
        d.wpend[p] = 1'b0;
        d.wresp[p] = 1'b1;
      end
    end
    if (MEM_WDONE_I && q.port[P_AXI + MEM_WDONE_PORT_I]) begin
      if (q.port[P_STR + MEM_WDONE_PORT_I]) begin
        d.wpend[MEM_WDONE_PORT_I] = 1'b1;
      end else begin
        d.wresp[MEM_WDONE_PORT_I] = 1'b1;
      end
    end
    if (MEM_WDONE_I && q.outst != 8'h00) begin
      d.outst = q.outst - 8'h01;
    end
    // Calibration and arbitration
    case (q.cal)
      ST_INIT: d.cal = ST_CALWR;
      ST_CALWR: begin
        if (mem_free) begin
          issue = 1'b1;
          d.mvalid = 1'b1;
          d.mwrite = 1'b1;
          d.mcal = 1'b1;
          d.ap = 1'b0;
          d.mport = '0;
          {d.row, d.bank, d.col} = q.caladdr[AW-1:0];
          d.calcnt = CAL_CYC;
          d.cal = ST_CALRUN;
        end
      end
      ST_CALRUN: begin
        // Count only once the training write has left
        if (!q.mvalid) begin
          d.calcnt = q.calcnt - 8'h01;
          if (q.calcnt == 8'h01) begin
            d.cal = ST_RUN;
          end
        end
      end
      ST_RUN: begin
        if (recal_edge) begin
          d.cal = ST_CALWR;
        end else if (mem_free && found) begin
          d.cready[pick] = 1'b1;
          d.slot = q.slot + 3'h1;
          d.rr = pick + PW'(1);
          bad = (UNI_MASK[pick] && (CMD_WRITE_I[pick] != q.port[P_DIR + pick]))
                || (CMD_NARROW_I[pick] && !q.port[P_NAR]);
          if (bad) begin
            d.err = 1'b1;
          end else begin
            issue = 1'b1;
            d.mvalid = 1'b1;
            d.mwrite = CMD_WRITE_I[pick];
            d.mcal = 1'b0;
            d.ap = q.port[P_AP + pick];
            d.mport = pick;
            // Bank above column lets a column overrun open the next bank
            if (q.ctrl[C_MAP]) begin
              {d.bank, d.row, d.col} = addr_sel;
            end else begin
              {d.row, d.bank, d.col} = addr_sel;
            end
            if (CMD_WRITE_I[pick]) begin
              d.outst = d.outst + 8'h01;
            end
          end
        end
      end
      default: d.cal = ST_INIT;
    endcase
    d.caldone = (d.cal == ST_RUN);
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      q <= '0;
      q.ctrl <= CTRL_RST;
      q.port <= PORT_RST;
      q.arb0 <= ARB_RST;
      q.arb1 <= ARB_RST;
      q.caladdr <= CAL_RST;
      q.cal <= SIM_BYPASS_CAL ? ST_RUN : ST_INIT;
      q.caldone <= SIM_BYPASS_CAL;
    end else begin
      q <= d;
    end
  end

  // ==========================================
  // Outputs
  assign PRDATA_O = q.prdata;
  assign PREADY_O = q.pready;
  assign PSLVERR_O = q.pslverr;
  assign CMD_READY_O = q.cready;
  assign WRESP_O = q.wresp;
  assign MEM_CMD_VALID_O = q.mvalid;
  assign MEM_WRITE_O = q.mwrite;
  assign MEM_AP_O = q.ap;
  assign MEM_CAL_O = q.mcal;
  assign MEM_ROW_O = q.row;
  assign MEM_BANK_O = q.bank;
  assign MEM_COL_O = q.col;
  assign MEM_PORT_O = q.mport;
  assign CAL_DONE_O = q.caldone;

  // ==========================================
  // Assertions
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  sequence s_recal;
    recal_edge && q.cal == ST_RUN;
  endsequence
  sequence s_train;
    MEM_CMD_VALID_O && MEM_WRITE_O && MEM_CAL_O;
  endsequence

  grant_onehot_a: assert property ($onehot0(CMD_READY_O))
    else $error("more than one port granted");
  disabled_port_a: assert property (|CMD_READY_O |-> |(CMD_READY_O & $past(act)))
    else $error("grant to disabled port");
  direction_only_a: assert property (issue && !d.mcal |=>
      (!UNI_MASK[q.mport] || q.mwrite == $past(q.port[P_DIR + d.mport])))
    else $error("wrong direction on unidirectional port");
  auto_pre_a: assert property (issue && !d.mcal |=> MEM_AP_O == $past(q.port[P_AP + pick]))
    else $error("auto precharge mismatch");
  addr_map_a: assert property (issue && !d.mcal |=> $past(addr_sel) == ($past(q.ctrl[C_MAP]) ?
      {MEM_BANK_O, MEM_ROW_O, MEM_COL_O} : {MEM_ROW_O, MEM_BANK_O, MEM_COL_O}))
    else $error("address split wrong");
  strict_resp_a: assert property (|(WRESP_O & q.port[P_STR +: NP]) |-> $past(q.outst) == 8'h00)
    else $error("strict response while writes pending");
  top_entry_a: assert property (q.cal == ST_RUN && !recal_edge && mem_free && elig[ent[0]]
      |=> CMD_READY_O[$past(ent[0])])
    else $error("top entry not granted");
  pass_down_a: assert property (q.cal == ST_RUN && !recal_edge && mem_free && !elig[ent[0]]
      && elig[ent[1]] |=> CMD_READY_O[$past(ent[1])])
    else $error("grant not passed to next entry");
  recal_train_a: assert property (s_recal |=> q.cal == ST_CALWR ##[1:1000] s_train)
    else $error("no training write after recal request");
  done_after_cal_a: assert property ($rose(CAL_DONE_O) |-> $past(q.cal) == ST_CALRUN)
    else $error("calibration done without calibration");
  no_port_a: assert property (q.ctrl[C_CFG +: 3] > CFG_LAST |=> CMD_READY_O == '0)
    else $error("grant with no port configured");
  early_resp_a: assert property (MEM_WDONE_I && q.port[P_AXI + MEM_WDONE_PORT_I]
      && !q.port[P_STR + MEM_WDONE_PORT_I] |=> WRESP_O[$past(MEM_WDONE_PORT_I)])
    else $error("early write response missing");
  cal_gate_a: assert property (|CMD_READY_O |-> $past(q.cal) == ST_RUN)
    else $error("port granted during calibration");
endmodule

/* File: mpf_front_end_unused_guard.sv */
`timescale 1ns/1ns

/* File: mpf_mem_model.sv */
`timescale 1ns/1ns
module mpf_mem_model import mpf_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic valid_i,
  input wire logic write_i,
  input wire logic cal_i,
  input wire logic [PW-1:0] port_i,
  input wire logic [1:0] dly_i,
  output logic ready_o,
  output logic wdone_o,
  output logic [PW-1:0] wdone_port_o
);
  typedef struct packed {
    logic rdy;
    logic [1:0] cnt;
    logic [2:0] pv;
    logic [5:0] pp;
  } mpf_mm_t;
  mpf_mm_t s_q;
  mpf_mm_t s_d;
  // ==========================================
  // Accept after dly_i + 1 waiting cycles
  always_comb begin
    s_d = s_q;
    // Training writes never report completion
    s_d.pv = {s_q.pv[1:0], s_q.rdy & valid_i & write_i & ~cal_i};
    s_d.pp = {s_q.pp[3:0], port_i};
    s_d.rdy = 1'b0;
    if (valid_i && !s_q.rdy) begin
      s_d.cnt = s_q.cnt + 2'h1;
      if (s_q.cnt >= dly_i) begin
        s_d.rdy = 1'b1;
        s_d.cnt = 2'h0;
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) s_q <= '0;
    else s_q <= s_d;
  end
  assign ready_o = s_q.rdy;
  assign wdone_o = s_q.pv[2];
  assign wdone_port_o = s_q.pp[5:4];
endmodule

/* File: mpf_front_end_tb.sv */
`timescale 1ns/1ns
module mpf_front_end_tb import mpf_pkg::*; ();
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, recal = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
  logic [3:0] cv = 4'h0, cw = 4'h0, cn = 4'h0, crdy, wresp, gm, gf, wm;
  logic [111:0] ca = 112'h0;
  logic [1:0] dly = 2'h0, mport, wdp, lport;
  logic pready, pslverr, er, mv, mw, mapc, mcal, mrdy, wdn, cdone, lw, lap, lcal;
  logic [14:0] mrow;
  logic [2:0] mbank;
  logic [9:0] mcol;
  logic [27:0] lf;
  int miscompares = 0, samples_checked = 0, mcnt = 0, wcnt = 0;
  always #2 clk = ~clk;
  mpf_front_end #(.SIM_BYPASS_CAL(1'b0)) dut (.CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .CMD_VALID_I(cv), .CMD_WRITE_I(cw),
    .CMD_NARROW_I(cn), .CMD_ADDR_I(ca), .CMD_READY_O(crdy), .WRESP_O(wresp),
    .MEM_CMD_VALID_O(mv), .MEM_WRITE_O(mw), .MEM_AP_O(mapc), .MEM_CAL_O(mcal),
    .MEM_ROW_O(mrow), .MEM_BANK_O(mbank), .MEM_COL_O(mcol), .MEM_PORT_O(mport),
    .MEM_CMD_READY_I(mrdy), .MEM_WDONE_I(wdn), .MEM_WDONE_PORT_I(wdp),
    .RECAL_REQ_I(recal), .CAL_DONE_O(cdone));
  mpf_mem_model mem (.clk_i(clk), .rst_n_i(rst_n), .valid_i(mv), .write_i(mw), .cal_i(mcal),
    .port_i(mport), .dly_i(dly), .ready_o(mrdy), .wdone_o(wdn), .wdone_port_o(wdp));
  // ==========================================
  // Monitor, sampled off the active edge
  always @(negedge clk) begin
    gm = gm | crdy;
    wm = wm | wresp;
    if (gf === 4'h0) gf = crdy;
    if (wresp !== 4'h0) wcnt++;
    if (mv === 1'b1 && mrdy === 1'b1) begin
      mcnt++;
      {lw, lap, lcal, lport, lf} = {mw, mapc, mcal, mport, mrow, mbank, mcol};
    end
  end
  // ==========================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {psel, pwr, paddr, pwdata} <= {1'b1, w, 24'h0, a, d};
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(negedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) miscompares++;
    // Answer taken at the edge that samples ready high, then released
    @(posedge clk);
    {rd, er} = {prdata, pslverr};
    {psel, pen} <= 2'b00;
  endtask
  task automatic wait_cal(input logic v);
    int n;
    n = 0;
    while (cdone !== v && n < 300) begin
      @(negedge clk);
      n++;
    end
    if (cdone !== v) miscompares++;
  endtask
  task automatic req(input int p, input logic w, input logic nr, input logic [27:0] a);
    int n;
    n = 0;
    @(posedge clk);
    {cv[p], cw[p], cn[p], ca[p*28 +: 28]} <= {1'b1, w, nr, a};
    do begin
      @(negedge clk);
      n++;
    end while (crdy[p] !== 1'b1 && n < 50);
    if (crdy[p] !== 1'b1) miscompares++;
    @(posedge clk);
    cv[p] <= 1'b0;
    repeat (12) @(negedge clk);
  endtask
  function automatic logic [27:0] fld(input logic m, input logic [27:0] a);
    return m ? {a[24:10], a[27:25], a[9:0]} : a;
  endfunction
  // Grant expected from one slot's ranking and the requesting ports
  function automatic logic [3:0] first_ok(input logic [7:0] b, input logic [3:0] m);
    first_ok = 4'h0;
    for (int k = 3; k >= 0; k--) begin
      if (m[b[2*k +: 2]]) first_ok = 4'h1 << b[2*k +: 2];
    end
  endfunction
  // ==========================================
  // Scenarios
  task automatic t_cal();
    wait_cal(1'b1);
    chk(mcnt, 1);
    chk({lcal, lw}, 2'b11);
    apb(1'b1, A_CAL, 32'h01234567);
    @(posedge clk);
    recal <= 1'b1;
    wait_cal(1'b0);
    chk(cdone, 1'b0);
    wait_cal(1'b1);
    chk({lcal, lw, lf}, {2'b11, 28'h1234567});
    @(posedge clk);
    recal <= 1'b0;
  endtask
  task automatic t_reg();
    apb(1'b0, A_CTRL, 32'h0);
    chk(rd[C_CUST], 1'b0);
    apb(1'b1, 8'h20, 32'hffffffff);
    apb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, er}, 32'h1);
  endtask
  task automatic t_map();
    int w0;
    int n;
    apb(1'b1, A_PORT, PORT_RST | 32'h00010100);
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, A_CTRL, m << C_MAP);
      w0 = wcnt;
      req(0, 1'b1, 1'b0, 28'h00123ff);
      chk(lf, fld(m[0], 28'h00123ff));
      chk({lw, lap, lport}, 4'hc);
      chk(wcnt, w0 + 1);
      req(0, 1'b0, 1'b0, 28'h0012400);
      chk(lf, fld(m[0], 28'h0012400));
      chk(lap, 1'b1);
      req(1, 1'b1, 1'b0, 28'h0000040);
      chk(wcnt, w0 + 1);
    end
    // Two ports in use, both strict: one joint response after the last write
    apb(1'b1, A_PORT, PORT_RST | 32'h00003300);
    w0 = wcnt;
    n = 0;
    @(posedge clk);
    {gm, wm} = 8'h00;
    {cv, cw} <= 8'h33;
    while (gm !== 4'h3 && n < 50) begin
      @(negedge clk);
      n++;
    end
    if (gm !== 4'h3) miscompares++;
    @(posedge clk);
    cv <= 4'h0;
    repeat (16) @(negedge clk);
    chk(wcnt, w0 + 1);
    chk(wm, 4'h3);
  endtask
  task automatic t_cfg();
    logic [3:0] en;
    int c;
    @(posedge clk);
    dly <= 2'h2;
    for (int i = 0; i < 7; i++) begin
      c = (i < 5) ? i : ((i == 5) ? 0 : 5);
      en = (i == 5) ? 4'hd : 4'hf;
      apb(1'b1, A_CTRL, c);
      apb(1'b1, A_PORT, {PORT_RST[31:4], en});
      @(posedge clk);
      gm = 4'h0;
      {cv, cw, cn} <= {4'hf, 4'h0, 4'h0};
      repeat (40) @(posedge clk);
      cv <= 4'h0;
      repeat (4) @(negedge clk);
      chk(gm, (c > 4) ? 4'h0 : CFG_MASK[c] & en);
    end
    @(posedge clk);
    dly <= 2'h0;
  endtask
  task automatic t_arb();
    int n;
    logic [63:0] tt;
    logic [7:0] b;
    logic [3:0] m;
    // Each port tops at least one slot
    tt = 64'h934e39e4934e39e4;
    apb(1'b1, A_ARB0, tt[31:0]);
    apb(1'b1, A_ARB1, tt[63:32]);
    apb(1'b1, A_CTRL, 32'h1 << C_CUST);
    for (int k = 0; k < 2; k++) begin
      // Slot pointer is read back, so any history before this scenario is fine
      apb(1'b0, A_STAT, 32'h0);
      b = tt[rd[S_SLOT +: 3] * 8 +: 8];
      m = k ? ~(4'h1 << b[1:0]) : 4'hf;
      n = 0;
      @(posedge clk);
      gf = 4'h0;
      cv <= m;
      while (gf === 4'h0 && n < 50) begin
        @(negedge clk);
        n++;
      end
      if (gf === 4'h0) miscompares++;
      @(posedge clk);
      cv <= 4'h0;
      repeat (4) @(posedge clk);
      chk(gf, first_ok(b, m));
    end
  endtask
  task automatic t_err();
    int m0;
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, A_PORT, k ? 32'h0000000f : PORT_RST);
      m0 = mcnt;
      if (k == 0) req(2, 1'b1, 1'b0, 28'h0000100);
      else req(0, 1'b0, 1'b1, 28'h0000100);
      chk(mcnt, m0);
      apb(1'b0, A_STAT, 32'h0);
      chk(rd[S_ERR], 1'b1);
      apb(1'b1, A_STAT, 32'h1 << S_ERR);
      apb(1'b0, A_STAT, 32'h0);
      chk(rd[S_ERR], 1'b0);
    end
  endtask
  task automatic results();
    $display("samples_checked=%0d miscompares=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reg();
    t_cal();
    t_map();
    t_cfg();
    t_arb();
    t_err();
    results();
  end
  // Whole run needs under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    results();
  end
endmodule
